// ---- rtl/high_voltage_config_regs.sv ----
// Purpose: Indirect command interface and decoded high-voltage controls
// Assumes: Command strobe only when busy is low
// Notes:   Reserved LIN codes leave the driver off
`timescale 1ns/1ps
module high_voltage_config_regs (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   // Command and data registers
   input  wire logic        i_cmd_we,
   input  wire logic [3:0]  i_cmd,
   input  wire logic        i_dat_we,
   input  wire logic [7:0]  i_dat,
   output logic             o_busy,
   output logic             o_rd_ok,
   output logic             o_wr_ok,
   output logic [11:0]      o_data_reg,
   // Analog side inputs and interrupt enable mask
   input  wire logic        i_thermal_event,
   input  wire logic        i_supply_low,
   input  wire logic        i_core_dropped,
   input  wire logic [31:0] i_irq_enable,
   // Decoded controls
   output logic             o_wake_drv_en,
   output logic             o_osc_en,
   output logic             o_lin_pullup_en,
   output logic             o_bit_serial_mode,
   output logic             o_wake_pin,
   output logic             o_wake_pin_oe,
   output logic             o_supply_monitor_en,
   output logic             o_supply_irq,
   output logic             o_low_voltage_flag,
   output logic             o_lin_drv_en,
   output logic [7:0]       o_hv_config_first,
   output logic [7:0]       o_hv_config_second
);
   import hv_cfg_pkg::*;

   // ----------------------------------------
   // Command decode
   // ----------------------------------------
   logic [3:0] pend_cmd;
   logic [7:0] rdata;
   logic [1:0] cnt;
   logic       lvf_latch;
   wire        is_rd   = (i_cmd == CMD_RD_FIRST) || (i_cmd == CMD_RD_SECOND);
   wire        is_wr   = (i_cmd == CMD_WR_FIRST) || (i_cmd == CMD_WR_SECOND);
   wire        accept  = i_cmd_we && !o_busy;
   wire        done    = o_busy && (cnt == 2'(LATENCY_CYC - 1));
   wire        st_we   = done && pend_cmd[3];
   wire        st_sel  = pend_cmd[0];
   wire [7:0]  cfg0    = o_hv_config_first;

   hv_cfg_store u_store (
      .i_clk    (i_clk),
      .i_rst    (i_rst),
      .i_we     (st_we),
      .i_sel    (st_sel),
      .i_wdata  (o_data_reg[7:0]),
      .o_rdata  (rdata),
      .o_first  (o_hv_config_first),
      .o_second (o_hv_config_second)
   );

   // ----------------------------------------
   // Sequencing; latency keeps busy visible
   // ----------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_busy   <= 1'b0;
         o_rd_ok  <= 1'b0;
         o_wr_ok  <= 1'b0;
         cnt      <= 2'h0;
         pend_cmd <= 4'h0;
      end else if (accept && (is_rd || is_wr)) begin
         o_busy   <= 1'b1;
         cnt      <= 2'h0;
         pend_cmd <= i_cmd;
      end else if (done) begin
         o_busy   <= 1'b0;
         o_rd_ok  <= !pend_cmd[3];
         o_wr_ok  <= pend_cmd[3];
      end else if (o_busy) begin
         cnt      <= cnt + 2'h1;
      end
   end

   // Data register: command tag above data byte
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_data_reg <= 12'h000;
      end else if (o_busy && !pend_cmd[3] && cnt == 2'(LATENCY_CYC - 1)) begin
         // Registered store output; no write can land while a read is pending
         o_data_reg <= {pend_cmd, rdata};
      end else if (i_dat_we && !o_busy) begin
         o_data_reg <= {4'h0, i_dat};
      end
   end

   // ----------------------------------------
   // Decoded controls
   // ----------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_wake_drv_en       <= 1'b0;
         o_osc_en            <= 1'b0;
         o_lin_pullup_en     <= 1'b0;
         o_bit_serial_mode   <= 1'b0;
         o_wake_pin          <= 1'b0;
         o_wake_pin_oe       <= 1'b0;
         o_supply_monitor_en <= 1'b0;
         o_supply_irq        <= 1'b0;
         o_low_voltage_flag  <= 1'b0;
         o_lin_drv_en        <= 1'b0;
         lvf_latch           <= 1'b0;
      end else begin
         o_wake_drv_en       <= cfg0[BIT_THERM_DIS] || !i_thermal_event;
         o_osc_en            <= cfg0[BIT_OSC_EN];
         o_lin_pullup_en     <= !cfg0[BIT_BSD];
         o_bit_serial_mode   <= cfg0[BIT_BSD];
         o_wake_pin          <= cfg0[BIT_WAKE];
         o_wake_pin_oe       <= cfg0[BIT_WAKE] && (cfg0[BIT_THERM_DIS] || !i_thermal_event);
         o_supply_monitor_en <= cfg0[BIT_PSM];
         o_supply_irq        <= cfg0[BIT_PSM] && i_irq_enable[IRQ_SUPPLY_BIT] && i_supply_low;
         lvf_latch           <= cfg0[BIT_LVF] && (lvf_latch || i_core_dropped);
         o_low_voltage_flag  <= cfg0[BIT_LVF] && (lvf_latch || i_core_dropped);
         o_lin_drv_en        <= (cfg0[1:0] == LIN_ON);
      end
   end

   AST_BUSY_LEN: assert property (@(posedge i_clk) disable iff (i_rst)
      $rose(o_busy) |-> o_busy [*2] ##1 !o_busy) else $error("busy length wrong");
   AST_WR_FIRST: assert property (@(posedge i_clk) disable iff (i_rst)
      (accept && i_cmd == CMD_WR_FIRST) |-> ##3 (o_hv_config_first == $past(o_data_reg[7:0], 3)))
      else $error("first write lost");
   AST_STABLE: assert property (@(posedge i_clk) disable iff (i_rst)
      !st_we |=> $stable(o_hv_config_first) && $stable(o_hv_config_second))
      else $error("config changed without write");
   AST_LIN: assert property (@(posedge i_clk) disable iff (i_rst)
      ##1 o_lin_drv_en == ($past(cfg0[1:0]) == LIN_ON)) else $error("lin mode wrong");
   AST_PULLUP: assert property (@(posedge i_clk) disable iff (i_rst)
      !$past(i_rst) |-> o_lin_pullup_en != o_bit_serial_mode) else $error("pullup vs bsd");
   AST_OSC: assert property (@(posedge i_clk) disable iff (i_rst)
      ##1 o_osc_en == $past(cfg0[BIT_OSC_EN])) else $error("osc enable wrong");
   AST_THERM: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_thermal_event && !cfg0[BIT_THERM_DIS]) |=> !o_wake_drv_en) else $error("no shutdown");
   AST_WAKE: assert property (@(posedge i_clk) disable iff (i_rst)
      ##1 o_wake_pin == $past(cfg0[BIT_WAKE])) else $error("wake pin wrong");
   AST_IRQ: assert property (@(posedge i_clk) disable iff (i_rst)
      o_supply_irq |-> $past(cfg0[BIT_PSM] && i_supply_low)) else $error("spurious irq");
   AST_LVF: assert property (@(posedge i_clk) disable iff (i_rst)
      o_low_voltage_flag |-> $past(cfg0[BIT_LVF])) else $error("lvf without enable");
   AST_RD: assert property (@(posedge i_clk) disable iff (i_rst)
      (accept && i_cmd == CMD_RD_SECOND) |-> ##3 o_data_reg == {CMD_RD_SECOND, o_hv_config_second})
      else $error("read back wrong");
endmodule : high_voltage_config_regs

// ---- rtl/hv_cfg_pkg.sv ----
// Summary of operation
// - Bit 7 set keeps wake driver through thermal
// - Bit 6 powers the precision oscillator
// - Bit 5 selects bit-serial, drops pull-up
// - Bit 4 drives wake pin high, but its output enable drops during a thermal event with bit 7 clear
// - Bit 3 enables supply monitor interrupt path
// - Bit 2 enables low-voltage flag function
// - Bits 1:0 select LIN driver mode
// - Second register eight bits, reset zero, indirect
// - Commands 0/1 read, 8/9 write configs
// Purpose: Constants for the high-voltage configuration registers
// Assumes: Single clock, synchronous active-high reset
// Notes:   Commands arrive as 4-bit codes with an 8-bit data word
package hv_cfg_pkg;
   localparam logic [3:0] CMD_RD_FIRST  = 4'h0;
   localparam logic [3:0] CMD_RD_SECOND = 4'h1;
   localparam logic [3:0] CMD_WR_FIRST  = 4'h8;
   localparam logic [3:0] CMD_WR_SECOND = 4'h9;
   localparam logic [7:0] CFG_RESET     = 8'h00;
   localparam int         BIT_THERM_DIS = 7;
   localparam int         BIT_OSC_EN    = 6;
   localparam int         BIT_BSD       = 5;
   localparam int         BIT_WAKE      = 4;
   localparam int         BIT_PSM       = 3;
   localparam int         BIT_LVF       = 2;
   localparam logic [1:0] LIN_ON        = 2'h2;
   localparam int         IRQ_SUPPLY_BIT = 16;
   localparam int         LATENCY_CYC   = 2;
endpackage : hv_cfg_pkg

// ---- rtl/hv_cfg_store.sv ----
// Purpose: Two-word configuration store with registered read data
// Assumes: One write or read per cycle
// Notes:   Word 0 is the first register, word 1 the second
`timescale 1ns/1ps
module hv_cfg_store (
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   // Access
   input  wire logic       i_we,
   input  wire logic       i_sel,
   input  wire logic [7:0] i_wdata,
   output logic [7:0]      o_rdata,
   output logic [7:0]      o_first,
   output logic [7:0]      o_second
);
   import hv_cfg_pkg::*;
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_first  <= CFG_RESET;
         o_second <= CFG_RESET;
      end else if (i_we && !i_sel) begin
         o_first  <= i_wdata;
      end else if (i_we && i_sel) begin
         o_second <= i_wdata;
      end
   end
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_rdata <= 8'h00;
      end else begin
         o_rdata <= i_sel ? o_second : o_first;
      end
   end
endmodule : hv_cfg_store

// ---- verif/tb_top.sv ----
// Purpose: Self-checking bench for the high-voltage configuration registers
// Assumes: Two-cycle busy latency, decoded outputs one cycle behind the register
// Notes:   Only legal LIN codes are written; busy is always clear before a command
`timescale 1ns/1ps
module tb_top;
   import hv_cfg_pkg::*;
   // ---------------------------------------------
   // Signals
   // ---------------------------------------------
   logic        i_clk = 1'b0, i_rst = 1'b1, i_cmd_we = 1'b0, i_dat_we = 1'b0;
   logic [3:0]  i_cmd = 4'h0;
   logic [7:0]  i_dat = 8'h00;
   logic        i_thermal_event = 1'b1, i_supply_low = 1'b1, i_core_dropped = 1'b0;
   logic [31:0] i_irq_enable = 32'h0001_0000;
   logic        o_busy, o_rd_ok, o_wr_ok, o_wake_drv_en, o_osc_en, o_lin_pullup_en;
   logic        o_bit_serial_mode, o_wake_pin, o_wake_pin_oe, o_supply_monitor_en;
   logic        o_supply_irq, o_low_voltage_flag, o_lin_drv_en;
   logic [11:0] o_data_reg;
   logic [7:0]  o_hv_config_first, o_hv_config_second;
   logic [7:0]  vals [4] = '{8'hfe, 8'h5a, 8'h00, 8'h46};
   int          n_fail = 0, compares = 0;
   always #4 i_clk = ~i_clk;
   high_voltage_config_regs u_dut (.*);
   // ---------------------------------------------
   // Tasks
   // ---------------------------------------------
   task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
      compares++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", nm, exp, got);
         n_fail++;
      end
   endtask : chk
   task automatic issue(input logic [3:0] c, input logic exp_busy);
      @(posedge i_clk) begin i_dat_we <= 1'b0; i_cmd_we <= 1'b1; i_cmd <= c; end
      @(posedge i_clk) i_cmd_we <= 1'b0;
      @(posedge i_clk) #1 chk("busy_rise", exp_busy, o_busy);
      repeat (2) @(posedge i_clk);
      #1 chk("busy_drop", 1'b0, o_busy);
      @(posedge i_clk) #1;
   endtask : issue
   task automatic wr(input logic [3:0] c, input logic [7:0] d);
      @(posedge i_clk) begin i_dat_we <= 1'b1; i_dat <= d; end
      issue(c, 1'b1);
      chk("wr_ok", 1'b1, o_wr_ok);
   endtask : wr
   task automatic outs(input logic [7:0] v);
      chk("first", v, o_hv_config_first);
      chk("therm", v[7] | !i_thermal_event, o_wake_drv_en);
      chk("osc", v[6], o_osc_en);
      chk("bsd", v[5], o_bit_serial_mode);
      chk("pullup", !v[5], o_lin_pullup_en);
      chk("wake", v[4], o_wake_pin);
      chk("wake_oe", v[4] & (v[7] | !i_thermal_event), o_wake_pin_oe);
      chk("psm", v[3], o_supply_monitor_en);
      chk("irq", v[3] & i_irq_enable[IRQ_SUPPLY_BIT] & i_supply_low, o_supply_irq);
      chk("lin", v[1:0] == 2'b10, o_lin_drv_en);
   endtask : outs
   task automatic final_report;
      if (n_fail == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report
   // ---------------------------------------------
   // Tests
   // ---------------------------------------------
   initial begin
      repeat (5) @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk) #1;
      chk("second_rst", 8'h00, o_hv_config_second);
      outs(8'h00);
      chk("lvf_rst", 1'b0, o_low_voltage_flag);
      foreach (vals[i]) begin
         wr(CMD_WR_FIRST, vals[i]);
         outs(vals[i]);
         issue(CMD_RD_FIRST, 1'b1);
         chk("rd_first", {4'h0, vals[i]}, o_data_reg);
         chk("rd_ok", 1'b1, o_rd_ok);
      end
      // Thermal event released, then low-voltage flag latched after a dip
      @(posedge i_clk) begin
         i_thermal_event <= 1'b0;
         i_core_dropped  <= 1'b1;
      end
      @(posedge i_clk) i_core_dropped <= 1'b0;
      repeat (3) @(posedge i_clk);
      #1 chk("therm_off", 1'b1, o_wake_drv_en);
      chk("lvf", 1'b1, o_low_voltage_flag);
      wr(CMD_WR_FIRST, 8'h5a);
      @(posedge i_clk) i_irq_enable <= 32'h0000_0000;
      repeat (2) @(posedge i_clk);
      #1 outs(8'h5a);
      chk("lvf_off", 1'b0, o_low_voltage_flag);
      wr(CMD_WR_SECOND, 8'ha5);
      chk("second", 8'ha5, o_hv_config_second);
      chk("first_kept", 8'h5a, o_hv_config_first);
      issue(CMD_RD_SECOND, 1'b1);
      chk("rd_second", {4'h1, 8'ha5}, o_data_reg);
      // Unknown code is ignored and leaves the data register alone
      issue(4'h5, 1'b0);
      chk("rd_kept", {4'h1, 8'ha5}, o_data_reg);
      final_report();
   end
   // Whole sequence needs well under 200 cycles
   initial begin
      #20000;
      n_fail++;
      final_report();
   end
endmodule : tb_top
